// ---- verilog/fc_login_pkg.sv ----
// Constants, types and helpers shared by the login and task-management logic
package fc_login_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_UNIT_ID = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_COMPANY = 8'h0C;
  localparam logic [7:0] REG_CONN_FS = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOGOUT_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [23:0] UNIT_ID_RESET = 24'h000000;

  // ==========================================================
  // Payload kinds and task management
  localparam logic [1:0] KIND_PLOGI = 2'h0;
  localparam logic [1:0] KIND_PRLI = 2'h1;
  localparam logic [1:0] KIND_PDISC = 2'h2;
  localparam logic [7:0] TMF_CLEAR_ACA = 8'h40;
  localparam logic [7:0] TMF_TARGET_RESET = 8'h20;
  localparam logic [7:0] TMF_TERMINATE = 8'h08;
  localparam logic [7:0] TMF_CLEAR_TASK_SET = 8'h04;
  localparam logic [7:0] TMF_ABORT_TASK_SET = 8'h02;
  localparam logic [7:0] RSP_COMPLETE = 8'h00;
  localparam logic [7:0] RSP_NOT_SUPP = 8'h04;
  localparam logic [7:0] RSP_REJECT = 8'h05;

  // ==========================================================
  // Login payload layout
  localparam logic [6:0] PLOGI_LEN = 7'd116;
  localparam logic [6:0] PRLI_LEN = 7'd20;
  localparam logic [6:0] IDX_MAX = 7'd127;
  localparam logic [6:0] IDX_CMD = 7'd0;
  localparam logic [6:0] IDX_VER_HI = 7'd4;
  localparam logic [6:0] IDX_VER_LO = 7'd5;
  localparam logic [6:0] IDX_CF = 7'd8;
  localparam logic [6:0] IDX_FSC_HI = 7'd10;
  localparam logic [6:0] IDX_FSC_LO = 7'd11;
  localparam logic [6:0] IDX_PORT = 7'd20;
  localparam logic [6:0] IDX_PN_LAST = 7'd27;
  localparam logic [6:0] IDX_CC1 = 7'd22;
  localparam logic [6:0] IDX_UI1 = 7'd25;
  localparam logic [6:0] IDX_CC2 = 7'd30;
  localparam logic [6:0] IDX_UI2 = 7'd33;
  localparam logic [6:0] IDX_SO = 7'd68;
  localparam logic [6:0] IDX_IC = 7'd70;
  localparam logic [6:0] IDX_FS3_HI = 7'd74;
  localparam logic [6:0] IDX_FS3_LO = 7'd75;
  localparam logic [6:0] IDX_CS = 7'd77;
  localparam logic [6:0] IDX_OS_HI = 7'd80;
  localparam logic [6:0] IDX_OS_LO = 7'd81;
  localparam logic [7:0] PLOGI_CMD = 8'h03;
  localparam logic [7:0] VERSION = 8'h09;
  localparam int CF_CIO_BIT = 7;
  localparam int CF_NF_BIT = 4;
  localparam int CF_ACM_BIT = 3;
  localparam int SO_VALID_BIT = 7;
  localparam int IC_PA_HI_BIT = 5;
  localparam int FS_W = 12;
  localparam logic [11:0] FS_MIN = 12'h080;
  localparam logic [11:0] FS_MAX = 12'h840;
  localparam logic [11:0] FS_ALIGN = 12'h003;
  localparam logic [15:0] BB_CREDIT = 16'h0000;
  localparam logic [6:0] PRLI_HDR_LEN = 7'd5;
  localparam logic [39:0] PRLI_REQ_HDR = 40'h2010001408;

  // Accept templates, byte 0 in the top bits; variable fields are overlaid
  localparam logic [927:0] PLOGI_ACC = {
    128'h0200_0000_0909_0000_8800_0000_00FF_0001,
    128'h0000_01F4_2000_0000_0000_0000_2000_0000,
    256'h0,
    128'h0000_0000_8000_0000_0000_0000_00FF_0000,
    128'h0001_0000_0000_0000_0000_0000_0000_0000,
    160'h0};
  localparam logic [159:0] PRLI_ACC = 160'h0210_0014_0800_2100_0000_0000_0000_0000_0000_0012;

  // ==========================================================
  // States
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_DECIDE = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_TX = 5'b10000
  } main_st_t;

  // Receive-size window and word alignment
  function automatic logic fs_ok(input logic [15:0] v);
    logic [11:0] f;
    f = v[FS_W-1:0];
    return (f > FS_MIN) && (f < FS_MAX) && ((f & FS_ALIGN) == 12'h000);
  endfunction : fs_ok

endpackage : fc_login_pkg

// ---- verilog/plogi_field_check.sv ----
// Captures and checks the fields of an incoming port login payload
`timescale 1ns/100ps
module plogi_field_check
  import fc_login_pkg::*;
(
  input wire logic clk_i,             // System clock
  input wire logic rst_i,             // Async reset, high
  input wire logic take_i,            // Byte accepted this cycle
  input wire logic [6:0] idx_i,       // Byte position in payload
  input wire logic [7:0] data_i,      // Payload byte
  output logic ok_o,                  // All checked fields pass
  output logic [11:0] fs3_o,          // Class-3 receive_data_size
  output logic [63:0] port_name_o     // Initiator port_name_field
);

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] ver_hi;
    logic [7:0] ver_lo;
    logic [7:0] cf;
    logic [15:0] fsc;
    logic [7:0] so;
    logic [7:0] ic;
    logic [15:0] fs3;
    logic [7:0] cs;
    logic [15:0] os;
    logic [63:0] pn;
  } chk_t;

  chk_t s;
  chk_t next_s;

  // ==========================================================
  // Capture; credit, node name and unchecked bytes are dropped
  always_comb begin
    next_s = s;
    if (take_i) begin
      if (idx_i == IDX_CMD) begin
        next_s.cmd = data_i;
      end else if (idx_i == IDX_VER_HI) begin
        next_s.ver_hi = data_i;
      end else if (idx_i == IDX_VER_LO) begin
        next_s.ver_lo = data_i;
      end else if (idx_i == IDX_CF) begin
        next_s.cf = data_i;
      end else if (idx_i == IDX_FSC_HI) begin
        next_s.fsc[15:8] = data_i;
      end else if (idx_i == IDX_FSC_LO) begin
        next_s.fsc[7:0] = data_i;
      end else if (idx_i >= IDX_PORT && idx_i <= IDX_PN_LAST) begin
        next_s.pn[3'(IDX_PN_LAST - idx_i)*8 +: 8] = data_i;
      end else if (idx_i == IDX_SO) begin
        next_s.so = data_i;
      end else if (idx_i == IDX_IC) begin
        next_s.ic = data_i;
      end else if (idx_i == IDX_FS3_HI) begin
        next_s.fs3[15:8] = data_i;
      end else if (idx_i == IDX_FS3_LO) begin
        next_s.fs3[7:0] = data_i;
      end else if (idx_i == IDX_CS) begin
        next_s.cs = data_i;
      end else if (idx_i == IDX_OS_HI) begin
        next_s.os[15:8] = data_i;
      end else if (idx_i == IDX_OS_LO) begin
        next_s.os[7:0] = data_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Verdict; random offset bit and the other option bits are not looked at
  assign ok_o = (s.cmd == PLOGI_CMD) && (s.ver_hi == VERSION)
    && (s.ver_lo == VERSION)
    && s.cf[CF_CIO_BIT] && !s.cf[CF_NF_BIT] && s.cf[CF_ACM_BIT]
    && fs_ok(s.fsc) && fs_ok(s.fs3)
    && s.so[SO_VALID_BIT]
    && !s.ic[IC_PA_HI_BIT]
    && (s.cs != 8'h00)
    && (s.os != 16'h0000);
  assign fs3_o = s.fs3[FS_W-1:0];
  assign port_name_o = s.pn;

endmodule : plogi_field_check

// ---- verilog/accept_payload_rom.sv ----
// Produces one byte of the port or process login accept payload
`timescale 1ns/100ps
module accept_payload_rom
  import fc_login_pkg::*;
(
  input wire logic prli_i,            // Process login accept selected
  input wire logic [6:0] idx_i,       // Byte position
  input wire logic [11:0] fs_i,       // receive_data_size to return
  input wire logic [1:0] port_i,      // Where the login arrived
  input wire logic [23:0] ui_i,       // unit_unique_identifier
  input wire logic [23:0] cc_i,       // company_identifier_bytes
  output logic [7:0] byte_o           // Payload byte
);

  always_comb begin
    byte_o = 8'h00;
    if (prli_i) begin
      if (idx_i < PRLI_LEN) begin
        byte_o = PRLI_ACC[8'(PRLI_LEN - 7'd1 - idx_i)*8 +: 8];
      end
    end else if (idx_i < PLOGI_LEN) begin
      byte_o = PLOGI_ACC[10'(PLOGI_LEN - 7'd1 - idx_i)*8 +: 8];
      if (idx_i == IDX_FSC_HI || idx_i == IDX_FS3_HI) begin
        byte_o = {4'h0, fs_i[11:8]};
      end else if (idx_i == IDX_FSC_LO || idx_i == IDX_FS3_LO) begin
        byte_o = fs_i[7:0];
      end else if (idx_i == IDX_PORT) begin
        byte_o = byte_o | {6'h00, port_i};
      end else if (idx_i >= IDX_CC1 && idx_i < IDX_UI1) begin
        byte_o = cc_i[5'(IDX_UI1 - 7'd1 - idx_i)*8 +: 8];
      end else if (idx_i >= IDX_UI1 && idx_i < IDX_UI1 + 7'd3) begin
        byte_o = ui_i[5'(IDX_UI1 + 7'd2 - idx_i)*8 +: 8];
      end else if (idx_i >= IDX_CC2 && idx_i < IDX_UI2) begin
        byte_o = cc_i[5'(IDX_UI2 - 7'd1 - idx_i)*8 +: 8];
      end else if (idx_i >= IDX_UI2 && idx_i < IDX_UI2 + 7'd3) begin
        byte_o = ui_i[5'(IDX_UI2 + 7'd2 - idx_i)*8 +: 8];
      end
    end
  end

endmodule : accept_payload_rom

// ---- verilog/fc_login_task_mgmt_handler.sv ----
// Target-side login payload checker, accept builder and task-management answerer
// How it works
// - Four management functions done; terminate unsupported
// - Answer codes 00 complete, 04 unsupported, 05 rejected
// - Incoming credit ignored; own credit zero
// - Require offset 1, node port, alternate credit
// - Random offset unchecked, returned as zero
// - Both sizes between 128, 2112, word-aligned
// - Only class-3 size used for framing
// - Class-3 size copied into accept, applied
// - Port name kept; changed pairing logs out
// - Node name neither checked nor kept
// - Class-valid must be one; others ignored
// - Process association 10 or 11 rejected
// - Concurrent sequences must exceed zero
// - Open sequences per exchange exceed zero
// - Fixed accept header, features 88, zero classes
// - Port digit: node 0, first 1, second 2
// - Unit identifier in port and node names
// - Company identifier at bytes 22, 30
// - Process accept 02 10 00 14, 21, 12
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
module fc_login_task_mgmt_handler
  import fc_login_pkg::*;
#(
  parameter int SLOTS = 4,
  parameter logic [23:0] COMPANY_ID = 24'h5A3C01 // Arbitrary value
) (
  input wire logic clk_i,             // System clock, 10 MHz
  input wire logic rst_i,             // Async reset, high
  input wire logic ce_i,              // Clock enable
  input wire logic [7:0] reg_addr_i,  // Register byte address
  input wire logic [31:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i,          // Write strobe
  input wire logic reg_rd_i,          // Read strobe
  output logic [31:0] reg_rdata_o,    // Read data, cycle after strobe
  input wire logic rx_valid_i,        // Login payload byte valid
  output logic rx_ready_o,            // Payload byte taken
  input wire logic [7:0] rx_data_i,   // Payload byte
  input wire logic rx_last_i,         // Last payload byte
  input wire logic [1:0] rx_kind_i,   // Payload kind
  input wire logic [7:0] rx_alpa_i,   // Initiator loop address
  input wire logic [1:0] rx_port_i,   // Arrival: node, first, second
  output logic rsp_valid_o,           // Verdict pulse
  output logic rsp_accept_o,          // Accept, else link-service reject
  output logic tx_valid_o,            // Accept byte valid
  input wire logic tx_ready_i,        // Accept byte taken
  output logic [7:0] tx_data_o,       // Accept byte
  output logic tx_last_o,             // Last accept byte
  input wire logic tmf_valid_i,       // Management request pulse
  input wire logic [7:0] tmf_func_i,  // Management flags
  output logic tmf_done_o,            // Management answer pulse
  output logic [7:0] tmf_code_o,      // Management answer code
  output logic [3:0] tmf_action_o,    // ACA, reset, clear set, abort set
  output logic [11:0] conn_fs_o,      // Frame size in force
  output logic [15:0] bb_credit_o     // Own buffer credit
);

  localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

  typedef struct packed {
    main_st_t st;
    logic [1:0] kind;
    logic [7:0] alpa;
    logic [1:0] port;
    logic [6:0] idx;
    logic hdr_bad;
    logic rsp_valid;
    logic rsp_accept;
    logic tx_prli;
    logic [6:0] tx_idx;
    logic [6:0] tx_len;
    logic [11:0] tx_fs;
    logic [7:0] tx_byte;
    logic tmf_done;
    logic [7:0] tmf_code;
    logic [3:0] tmf_act;
    logic enable;
    logic [23:0] ui;
    logic [31:0] rdata;
    logic last_rjt;
    logic [11:0] conn_fs;
    logic [SLOTS-1:0] slot_v;
    logic [SLOTS-1:0][7:0] slot_alpa;
    logic [SLOTS-1:0][63:0] slot_pn;
    logic [SLOTS-1:0][11:0] slot_fs;
  } state_t;

  state_t s;
  state_t next_s;

  // Slot holding an address, or the first free slot
  function automatic logic [SW:0] find_slot(input logic [SLOTS-1:0] v,
      input logic [SLOTS-1:0][7:0] al, input logic [7:0] a, input logic want_free);
    logic [SW:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (want_free ? !v[i] : (v[i] && al[i] == a)) begin
        r = {1'b1, SW'(i)};
      end
    end
    return r;
  endfunction : find_slot

  logic rx_take;
  logic [6:0] cur_idx;
  logic hdr_mis;
  logic chk_ok;
  logic [11:0] chk_fs3;
  logic [63:0] chk_pn;
  logic [SW:0] hit;
  logic [SW:0] free;
  logic [6:0] rom_idx;
  logic [7:0] rom_byte;
  logic tx_is_last;

  assign rx_ready_o = ce_i && (s.st == ST_IDLE || s.st == ST_RX);
  assign rx_take = rx_valid_i && rx_ready_o;
  assign cur_idx = (s.st == ST_IDLE) ? 7'd0 : s.idx;
  assign hdr_mis = (cur_idx < PRLI_HDR_LEN) &&
    (rx_data_i != PRLI_REQ_HDR[6'(PRLI_HDR_LEN - 7'd1 - cur_idx)*8 +: 8]);
  assign hit = find_slot(s.slot_v, s.slot_alpa, s.alpa, 1'b0);
  assign free = find_slot(s.slot_v, s.slot_alpa, s.alpa, 1'b1);
  assign rom_idx = (s.st == ST_TX) ? 7'(s.tx_idx + 7'd1) : s.tx_idx;
  assign tx_is_last = (s.tx_idx == 7'(s.tx_len - 7'd1));

  plogi_field_check u_check (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .take_i(rx_take),
    .idx_i(cur_idx),
    .data_i(rx_data_i),
    .ok_o(chk_ok),
    .fs3_o(chk_fs3),
    .port_name_o(chk_pn)
  );

  accept_payload_rom u_rom (
    .prli_i(s.tx_prli),
    .idx_i(rom_idx),
    .fs_i(s.tx_fs),
    .port_i(s.port),
    .ui_i(s.ui),
    .cc_i(COMPANY_ID),
    .byte_o(rom_byte)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    next_s.tmf_done = 1'b0;
    next_s.tmf_act = 4'h0;
    next_s.rdata = 32'h0000_0000;
    if (reg_wr_i) begin
      if (reg_addr_i == REG_CTRL) begin
        next_s.enable = reg_wdata_i[CTRL_EN_BIT];
        if (reg_wdata_i[CTRL_LOGOUT_BIT]) begin
          next_s.slot_v = '0;
        end
      end else if (reg_addr_i == REG_UNIT_ID) begin
        next_s.ui = reg_wdata_i[23:0];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == REG_CTRL) begin
        next_s.rdata = {31'h0000_0000, s.enable};
      end else if (reg_addr_i == REG_UNIT_ID) begin
        next_s.rdata = {8'h00, s.ui};
      end else if (reg_addr_i == REG_STATUS) begin
        next_s.rdata = {8'h00, s.tmf_code, 7'h00, s.last_rjt, 8'(s.slot_v)};
      end else if (reg_addr_i == REG_COMPANY) begin
        next_s.rdata = {8'h00, COMPANY_ID};
      end else if (reg_addr_i == REG_CONN_FS) begin
        next_s.rdata = {20'h00000, s.conn_fs};
      end
    end
    if (tmf_valid_i) begin
      next_s.tmf_done = 1'b1;
      if ($countones(tmf_func_i) != 1) begin
        next_s.tmf_code = RSP_REJECT;
      end else if (tmf_func_i == TMF_TERMINATE) begin
        next_s.tmf_code = RSP_NOT_SUPP;
      end else if (tmf_func_i == TMF_CLEAR_ACA || tmf_func_i == TMF_TARGET_RESET ||
          tmf_func_i == TMF_CLEAR_TASK_SET || tmf_func_i == TMF_ABORT_TASK_SET) begin
        next_s.tmf_code = RSP_COMPLETE;
        next_s.tmf_act = {tmf_func_i == TMF_CLEAR_ACA, tmf_func_i == TMF_TARGET_RESET,
          tmf_func_i == TMF_CLEAR_TASK_SET, tmf_func_i == TMF_ABORT_TASK_SET};
      end else begin
        next_s.tmf_code = RSP_NOT_SUPP;
      end
    end
    case (s.st)
      ST_IDLE: begin
        if (rx_take) begin
          next_s.kind = rx_kind_i;
          next_s.alpa = rx_alpa_i;
          next_s.port = rx_port_i;
          next_s.idx = 7'd1;
          next_s.hdr_bad = hdr_mis;
          next_s.st = rx_last_i ? ST_DECIDE : ST_RX;
        end
      end
      ST_RX: begin
        if (rx_take) begin
          next_s.idx = (s.idx == IDX_MAX) ? s.idx : 7'(s.idx + 7'd1);
          next_s.hdr_bad = s.hdr_bad | hdr_mis;
          if (rx_last_i) begin
            next_s.st = ST_DECIDE;
          end
        end
      end
      ST_DECIDE: begin
        next_s.rsp_valid = 1'b1;
        next_s.rsp_accept = 1'b0;
        next_s.tx_idx = 7'd0;
        next_s.tx_prli = 1'b0;
        next_s.tx_len = PLOGI_LEN;
        case (s.kind)
          KIND_PLOGI: begin
            if (s.enable && chk_ok && s.idx == PLOGI_LEN && (hit[SW] || free[SW])) begin
              next_s.rsp_accept = 1'b1;
              if (hit[SW]) begin
                next_s.slot_fs[hit[SW-1:0]] = chk_fs3;
                next_s.slot_pn[hit[SW-1:0]] = chk_pn;
              end else begin
                next_s.slot_v[free[SW-1:0]] = 1'b1;
                next_s.slot_alpa[free[SW-1:0]] = s.alpa;
                next_s.slot_fs[free[SW-1:0]] = chk_fs3;
                next_s.slot_pn[free[SW-1:0]] = chk_pn;
              end
              next_s.conn_fs = chk_fs3;
              next_s.tx_fs = chk_fs3;
            end
          end
          KIND_PRLI: begin
            if (s.enable && hit[SW] && !s.hdr_bad && s.idx == PRLI_LEN) begin
              next_s.rsp_accept = 1'b1;
              next_s.tx_prli = 1'b1;
              next_s.tx_len = PRLI_LEN;
            end
          end
          KIND_PDISC: begin
            if (hit[SW] && s.slot_pn[hit[SW-1:0]] == chk_pn) begin
              next_s.rsp_accept = 1'b1;
              next_s.tx_fs = s.slot_fs[hit[SW-1:0]];
            end else if (hit[SW]) begin
              next_s.slot_v[hit[SW-1:0]] = 1'b0;
            end
          end
          default: begin
            next_s.rsp_accept = 1'b0;
          end
        endcase
        next_s.last_rjt = !next_s.rsp_accept;
        next_s.st = next_s.rsp_accept ? ST_LOAD : ST_IDLE;
      end
      ST_LOAD: begin
        next_s.tx_byte = rom_byte;
        next_s.st = ST_TX;
      end
      ST_TX: begin
        if (tx_ready_i) begin
          if (tx_is_last) begin
            next_s.st = ST_IDLE;
          end else begin
            next_s.tx_idx = 7'(s.tx_idx + 7'd1);
            next_s.tx_byte = rom_byte;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.enable <= CTRL_EN_RESET;
      s.ui <= UNIT_ID_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = s.rdata;
  assign rsp_valid_o = s.rsp_valid;
  assign rsp_accept_o = s.rsp_accept;
  assign tx_valid_o = ce_i && (s.st == ST_TX);
  assign tx_data_o = s.tx_byte;
  assign tx_last_o = tx_valid_o && tx_is_last;
  assign tmf_done_o = s.tmf_done;
  assign tmf_code_o = s.tmf_code;
  assign tmf_action_o = s.tmf_act;
  assign conn_fs_o = s.conn_fs;
  assign bb_credit_o = BB_CREDIT;

  // ==========================================================
  // Checks
  property p_tmf_abort;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && tmf_valid_i && tmf_func_i == TMF_ABORT_TASK_SET)
      |=> (tmf_done_o && tmf_code_o == RSP_COMPLETE && tmf_action_o == 4'h1);
  endproperty
  a_tmf_abort: assert property (p_tmf_abort) else $error("abort set not completed");

  property p_tmf_term;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && tmf_valid_i && tmf_func_i == TMF_TERMINATE)
      |=> (tmf_code_o == RSP_NOT_SUPP && tmf_action_o == 4'h0);
  endproperty
  a_tmf_term: assert property (p_tmf_term) else $error("terminate not refused");

  property p_tmf_rej;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && tmf_valid_i && $countones(tmf_func_i) > 1) |=> tmf_code_o == RSP_REJECT;
  endproperty
  a_tmf_rej: assert property (p_tmf_rej) else $error("multi-flag request not rejected");

  property p_bad_login;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s.st == ST_DECIDE && s.kind == KIND_PLOGI && !chk_ok)
      |=> (rsp_valid_o && !rsp_accept_o) ##1 !tx_valid_o;
  endproperty
  a_bad_login: assert property (p_bad_login) else $error("bad login accepted");

  property p_acc_head;
    @(posedge clk_i) disable iff (rst_i)
    (tx_valid_o && !s.tx_prli && s.tx_idx == IDX_CF) |-> tx_data_o == 8'h88;
  endproperty
  a_acc_head: assert property (p_acc_head) else $error("accept features wrong");

  property p_port_digit;
    @(posedge clk_i) disable iff (rst_i)
    (tx_valid_o && !s.tx_prli && s.tx_idx == IDX_PORT) |-> tx_data_o == {6'h08, s.port};
  endproperty
  a_port_digit: assert property (p_port_digit) else $error("port digit wrong");

  property p_fs_copy;
    @(posedge clk_i) disable iff (rst_i)
    (tx_valid_o && !s.tx_prli && s.tx_idx == IDX_FS3_LO) |-> tx_data_o == s.tx_fs[7:0];
  endproperty
  a_fs_copy: assert property (p_fs_copy) else $error("class-3 size not returned");

  property p_prli_tail;
    @(posedge clk_i) disable iff (rst_i)
    (tx_valid_o && s.tx_prli && tx_last_o) |-> (tx_data_o == 8'h12 && s.tx_idx == 7'd19);
  endproperty
  a_prli_tail: assert property (p_prli_tail) else $error("process accept tail wrong");

  property p_pdisc_out;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s.st == ST_DECIDE && s.kind == KIND_PDISC && hit[SW]
      && s.slot_pn[hit[SW-1:0]] != chk_pn)
      |=> (!rsp_accept_o && $countones(s.slot_v) == $countones($past(s.slot_v)) - 1);
  endproperty
  a_pdisc_out: assert property (p_pdisc_out) else $error("changed name not logged out");

endmodule : fc_login_task_mgmt_handler

// ---- verification/login_initiator_model.sv ----
// Initiator model: streams a login payload and drains the accept with stalls
`timescale 1ns/100ps
module login_initiator_model (
  input wire logic clk_i, // System clock
  input wire logic go_i, // Start a payload
  input wire logic [6:0] len_i, // Payload bytes
  input wire logic [7:0] buf_i [116], // Payload
  input wire logic rx_ready_i, // Byte taken
  output logic rx_valid_o = 1'b0, // Byte offered
  output logic [7:0] rx_data_o = 8'h00, // Payload byte
  output logic rx_last_o = 1'b0, // Last byte
  input wire logic tx_valid_i, // Accept byte offered
  input wire logic [7:0] tx_data_i, // Accept byte
  output logic tx_ready_o = 1'b0, // Ready every other cycle
  output logic [7:0] acc_o [116] // Collected accept
);
  int n = 0;
  int k = 0;
  logic busy = 1'b0;
  always @(posedge clk_i) begin
    tx_ready_o <= ~tx_ready_o;
    if (tx_valid_i && tx_ready_o) begin
      acc_o[k] <= tx_data_i;
      k <= k + 1;
    end
    if (go_i) begin
      busy <= 1'b1;
      n <= 0;
      k <= 0;
    end else if (busy && (!rx_valid_o || rx_ready_i)) begin
      // Released data line shows the inverse of the last byte
      rx_valid_o <= (n < len_i);
      rx_data_o <= (n < len_i) ? buf_i[n] : ~rx_data_o;
      rx_last_o <= (n == len_i - 1);
      busy <= (n < len_i);
      n <= n + 1;
    end
  end
endmodule : login_initiator_model

// ---- verification/fc_login_task_mgmt_handler_tb_top.sv ----
// Self-checking bench for the login and task-management handler
`timescale 1ns/100ps
module fc_login_task_mgmt_handler_tb_top;
  import fc_login_pkg::*;
  localparam logic [23:0] CID = 24'h3C5A96; // Arbitrary value
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, go = 1'b0;
  logic tmf_valid_i = 1'b0, rx_valid_i, rx_ready_o, rx_last_i, rsp_valid_o, rsp_accept_o;
  logic tx_valid_o, tx_ready_i, tx_last_o, tmf_done_o;
  logic [1:0] rx_kind_i = 2'h0, rx_port_i = 2'h0;
  logic [3:0] tmf_action_o;
  logic [6:0] len = 7'h74;
  logic [7:0] reg_addr_i = 8'h00, rx_alpa_i = 8'h01, tmf_func_i = 8'h00;
  logic [7:0] rx_data_i, tx_data_o, tmf_code_o;
  logic [11:0] conn_fs_o;
  logic [15:0] bb_credit_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [7:0] pl [116], acc [116];
  int num_errors = 0, n_compared = 0, cycles = 0;
  always #50 clk_i = ~clk_i;
  fc_login_task_mgmt_handler #(.COMPANY_ID(CID)) dut_u (.*);
  login_initiator_model init_u (.clk_i, .go_i(go), .len_i(len), .buf_i(pl),
    .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .rx_last_o(rx_last_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i), .acc_o(acc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
    @(posedge clk_i);
  endtask : rd
  task automatic login(input logic [1:0] kind, input logic [6:0] l, input logic ok);
    rx_kind_i <= kind;
    rx_port_i <= 2'h2;
    len <= l;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (400) begin
      @(posedge clk_i);
      #1 if (rsp_valid_o === 1'b1) break;
    end
    chk({rsp_valid_o, rsp_accept_o}, {1'b1, ok});
    repeat (300) @(posedge clk_i);
  endtask : login
  task automatic fill();
    foreach (pl[i]) pl[i] = 8'h00;
    {pl[0], pl[4], pl[5], pl[6], pl[8], pl[10], pl[21]} = 56'h030909FFC808AB;
    {pl[68], pl[74], pl[75], pl[77], pl[81]} = 40'h8001F40101;
  endtask : fill
  task automatic t_tmf();
    logic [7:0] f [8] = '{8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h00, 8'h06, 8'h10};
    logic [11:0] e [8] = '{12'h008, 12'h004, 12'h040, 12'h002, 12'h001, 12'h050, 12'h050,
      12'h040};
    for (int i = 0; i < 8; i++) begin
      tmf_func_i <= f[i];
      tmf_valid_i <= 1'b1;
      @(posedge clk_i);
      tmf_valid_i <= 1'b0;
      #1 chk({tmf_done_o, tmf_code_o, tmf_action_o}, {1'b1, e[i]});
      @(posedge clk_i);
    end
    $display("t_tmf end");
  endtask : t_tmf
  task automatic t_checks();
    logic [6:0] ix [8] = '{7'd70, 7'd70, 7'd75, 7'd11, 7'd77, 7'd81, 7'd68, 7'd8};
    logic [7:0] v [8] = '{8'h20, 8'h10, 8'hF6, 8'h42, 8'h00, 8'h00, 8'h00, 8'h08};
    for (int i = 0; i < 8; i++) begin
      fill();
      pl[ix[i]] = v[i];
      login(KIND_PLOGI, 7'd116, i == 1);
    end
    $display("t_checks end");
  endtask : t_checks
  task automatic t_accept();
    wr(REG_UNIT_ID, 32'h00C3A55A);
    rd(REG_UNIT_ID, 32'h00C3A55A);
    rd(REG_COMPANY, {8'h00, CID});
    rd(8'hFC, 32'h0);
    fill();
    login(KIND_PLOGI, 7'd116, 1'b1);
    chk({acc[0], acc[6], acc[8], acc[13]}, 32'h020088FF);
    chk({acc[10], acc[11], acc[74], acc[75]}, 32'h01F401F4);
    chk({acc[20], CID}, {8'h22, acc[22], acc[23], acc[24]});
    chk({acc[30], acc[31], acc[32], acc[68]}, {CID, 8'h80});
    chk({acc[25], acc[26], acc[27], acc[35]}, 32'hC3A55A5A);
    chk({conn_fs_o, bb_credit_o}, 32'h1F40000);
    foreach (pl[i]) pl[i] = 8'h00;
    {pl[0], pl[1], pl[2], pl[3], pl[4], pl[19]} = 48'h201000140822;
    login(KIND_PRLI, 7'd20, 1'b1);
    chk({acc[0], acc[1], acc[2], acc[3]}, 32'h02100014);
    chk({acc[4], acc[6], acc[7], acc[19]}, 32'h08210012);
    $display("t_accept end");
  endtask : t_accept
  task automatic t_disc();
    fill();
    login(KIND_PDISC, 7'd116, 1'b1);
    pl[23] = 8'h5A;
    login(KIND_PDISC, 7'd116, 1'b0);
    rd(REG_STATUS, {8'h00, RSP_NOT_SUPP, 16'h0100});
    rd(REG_CONN_FS, 32'h0000_01F4);
    $display("t_disc end");
  endtask : t_disc
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error %0t: timeout", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_tmf();
    t_checks();
    t_accept();
    t_disc();
    print_verdict();
  end
endmodule : fc_login_task_mgmt_handler_tb_top
